//--- rtl/pffb_flag_bank.sv
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pffb_defines.svh"

module pffb_flag_bank
   import pffb_pkg::*;
(
   input  wire logic           clk_i,
   input  wire logic           rst_i,
   input  wire logic           wb_cyc_i,
   input  wire logic           wb_stb_i,
   input  wire logic           wb_we_i,
   input  wire logic [7:0]     wb_adr_i,
   input  wire logic [3:0]     wb_sel_i,
   input  wire logic [31:0]    wb_dat_i,
   output var  logic [31:0]    wb_dat_o,
   output var  logic           wb_ack_o,
   output var  logic           wb_err_o,
   input  wire pffb_thermal_t  therm_trig_i,
   input  wire pffb_lp_alert_t lp_alert_trig_i,
   input  wire pffb_lp_fault_t lp_fault_trig_i,
   input  wire pffb_pf_t       pf_alert_trig_i,
   input  wire pffb_pf_t       pf_status_trig_i,
   output logic                irq_o
);

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers

   function automatic logic [2:0] word_index(input logic [7:0] adr,
                                             input logic [7:0] base);
      logic [7:0] diff;
      diff = adr - base;
      word_index = diff[4:2];
   endfunction

   function automatic logic in_span(input logic [7:0] adr,
                                    input logic [7:0] lo,
                                    input logic [7:0] hi);
      in_span = (adr >= lo) && (adr <= hi) && (adr[1:0] == 2'b00);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   pffb_thermal_t  therm;
   pffb_lp_alert_t lp_alert;
   pffb_lp_fault_t lp_fault;
   pffb_pf_t       pf_alert;
   pffb_pf_t       pf_status;
   pffb_byte_t     en [5];
   logic [4:0]     irq_stat;
   logic [4:0]     irq_mask;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic       req;
   logic       is_flag;
   logic       is_en;
   logic       is_stat;
   logic       is_mask;
   logic       hit;
   logic       wr_ok;
   logic       rd_stat;
   logic [2:0] flag_idx;
   logic [2:0] en_idx;

   assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign is_flag  = in_span(wb_adr_i, `PFFB_OFF_THERM, `PFFB_OFF_PF_STATUS);
   assign is_en    = in_span(wb_adr_i, `PFFB_OFF_EN_BASE, `PFFB_OFF_EN_LAST);
   assign is_stat  = (wb_adr_i == `PFFB_OFF_IRQ_STAT);
   assign is_mask  = (wb_adr_i == `PFFB_OFF_IRQ_MASK);
   assign hit      = is_flag | is_en | is_stat | is_mask;
   assign flag_idx = word_index(wb_adr_i, `PFFB_OFF_THERM);
   assign en_idx   = word_index(wb_adr_i, `PFFB_OFF_EN_BASE);
   // Flag registers are not writable
   assign wr_ok    = req & wb_we_i & wb_sel_i[0];
   assign rd_stat  = req & ~wb_we_i & is_stat;

   ////////////////////////////////////////////////////////////////////////
   // Flag qualification: triggered and enabled

   pffb_thermal_t  next_therm;
   pffb_lp_alert_t next_lp_alert;
   pffb_lp_fault_t next_lp_fault;
   pffb_pf_t       next_pf_alert;
   pffb_pf_t       next_pf_status;

   pffb_thermal_t  therm_on;
   pffb_lp_alert_t lpa_on;
   pffb_lp_fault_t lpf_on;
   pffb_pf_t       pfa_on;
   pffb_pf_t       pfs_on;

   // Condition present and software enable set
   assign therm_on = therm_trig_i & en[0];
   assign lpa_on   = lp_alert_trig_i & en[1];
   assign lpf_on   = lp_fault_trig_i & en[2];
   assign pfa_on   = pf_alert_trig_i & en[3];
   assign pfs_on   = pf_status_trig_i & en[4];

   always_comb begin
      next_therm.fet_overtemp_flag       = therm_on.fet_overtemp_flag;
      next_therm.internal_overtemp_flag  = therm_on.internal_overtemp_flag;
      next_therm.discharge_overtemp_flag = therm_on.discharge_overtemp_flag;
      next_therm.charge_overtemp_flag    = therm_on.charge_overtemp_flag;
      next_therm.reserved_zero_bit       = 1'b0;
      next_therm.internal_undertemp_flag = therm_on.internal_undertemp_flag;
      next_therm.discharge_undertemp_flag = therm_on.discharge_undertemp_flag;
      next_therm.charge_undertemp_flag   = therm_on.charge_undertemp_flag;
   end

   always_comb begin
      next_lp_alert.tier3_discharge_overcurrent_flag = lpa_on.tier3_discharge_overcurrent_flag;
      next_lp_alert.short_circuit_latch_flag = lpa_on.short_circuit_latch_flag;
      next_lp_alert.discharge_overcurrent_latch_flag = lpa_on.discharge_overcurrent_latch_flag;
      next_lp_alert.cell_overvoltage_latch_flag = lpa_on.cell_overvoltage_latch_flag;
      // Suspend state is a status, not an enabled alert
      next_lp_alert.precharge_timeout_suspended = lp_alert_trig_i.precharge_timeout_suspended;
      next_lp_alert.reserved_zero_bit = 3'h0;
   end

   always_comb begin
      next_lp_fault.tier3_discharge_overcurrent_flag = lpf_on.tier3_discharge_overcurrent_flag;
      next_lp_fault.short_circuit_latch_flag = lpf_on.short_circuit_latch_flag;
      next_lp_fault.discharge_overcurrent_latch_flag = lpf_on.discharge_overcurrent_latch_flag;
      next_lp_fault.cell_overvoltage_latch_flag = lpf_on.cell_overvoltage_latch_flag;
      next_lp_fault.reserved_zero_bit = 1'b0;
      next_lp_fault.precharge_timeout_flag = lpf_on.precharge_timeout_flag;
      next_lp_fault.host_watchdog_flag = lpf_on.host_watchdog_flag;
      next_lp_fault.reserved_zero_bit_low = 1'b0;
   end

   always_comb begin
      next_pf_alert.copper_deposition_flag = pfa_on.copper_deposition_flag;
      next_pf_alert.safety_fet_overtemp_flag = pfa_on.safety_fet_overtemp_flag;
      next_pf_alert.reserved_zero_bit = 1'b0;
      next_pf_alert.safety_overtemp_flag = pfa_on.safety_overtemp_flag;
      next_pf_alert.safety_discharge_overcurrent_flag = pfa_on.safety_discharge_overcurrent_flag;
      next_pf_alert.safety_charge_overcurrent_flag = pfa_on.safety_charge_overcurrent_flag;
      next_pf_alert.safety_cell_overvoltage_flag = pfa_on.safety_cell_overvoltage_flag;
      next_pf_alert.safety_cell_undervoltage_flag = pfa_on.safety_cell_undervoltage_flag;
   end

   always_comb begin
      next_pf_status.copper_deposition_flag = pfs_on.copper_deposition_flag;
      next_pf_status.safety_fet_overtemp_flag = pfs_on.safety_fet_overtemp_flag;
      next_pf_status.reserved_zero_bit = 1'b0;
      next_pf_status.safety_overtemp_flag = pfs_on.safety_overtemp_flag;
      next_pf_status.safety_discharge_overcurrent_flag = pfs_on.safety_discharge_overcurrent_flag;
      next_pf_status.safety_charge_overcurrent_flag = pfs_on.safety_charge_overcurrent_flag;
      next_pf_status.safety_cell_overvoltage_flag = pfs_on.safety_cell_overvoltage_flag;
      next_pf_status.safety_cell_undervoltage_flag = pfs_on.safety_cell_undervoltage_flag;
   end

   ////////////////////////////////////////////////////////////////////////
   // Rising flags raise interrupt events

   logic [7:0] rise_therm;
   logic [7:0] rise_lp_alert;
   logic [7:0] rise_lp_fault;
   logic [7:0] rise_pf_alert;
   logic [7:0] rise_pf_status;
   logic [4:0] event_set;
   logic [4:0] next_irq_stat;

   assign rise_therm     = next_therm & ~therm;
   assign rise_lp_alert  = next_lp_alert & ~lp_alert;
   assign rise_lp_fault  = next_lp_fault & ~lp_fault;
   assign rise_pf_alert  = next_pf_alert & ~pf_alert;
   assign rise_pf_status = next_pf_status & ~pf_status;

   assign event_set[`PFFB_IRQ_THERM]     = |rise_therm;
   assign event_set[`PFFB_IRQ_LP_ALERT]  = |rise_lp_alert;
   assign event_set[`PFFB_IRQ_LP_FAULT]  = |rise_lp_fault;
   assign event_set[`PFFB_IRQ_PF_ALERT]  = |rise_pf_alert;
   assign event_set[`PFFB_IRQ_PF_STATUS] = |rise_pf_status;
   // Set wins over the read clear
   assign next_irq_stat = (irq_stat & {5{~rd_stat}}) | event_set;

   ////////////////////////////////////////////////////////////////////////
   // Read data

   pffb_byte_t flag_rd;
   pffb_byte_t rd_byte;

   always_comb begin
      unique case (flag_idx)
         3'h0:    flag_rd = therm;
         3'h1:    flag_rd = lp_alert;
         3'h2:    flag_rd = lp_fault;
         3'h3:    flag_rd = pf_alert;
         default: flag_rd = pf_status;
      endcase
   end

   assign rd_byte = is_flag ? flag_rd :
                    is_en   ? en[en_idx] :
                    is_stat ? {3'h0, irq_stat} :
                    is_mask ? {3'h0, irq_mask} : 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Flag and interrupt status registers

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         therm <= `PFFB_RST_FLAG;
      end else begin
         therm <= next_therm;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lp_alert <= `PFFB_RST_FLAG;
      end else begin
         lp_alert <= next_lp_alert;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lp_fault <= `PFFB_RST_FLAG;
      end else begin
         lp_fault <= next_lp_fault;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pf_alert <= `PFFB_RST_FLAG;
      end else begin
         pf_alert <= next_pf_alert;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pf_status <= `PFFB_RST_FLAG;
      end else begin
         pf_status <= next_pf_status;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= `PFFB_RST_IRQ;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Software enables and mask

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 5; i++) begin
            en[i] <= `PFFB_RST_EN;
         end
         irq_mask <= `PFFB_RST_IRQ;
      end else begin
         if (wr_ok && is_en) begin
            en[en_idx] <= wb_dat_i[7:0];
         end
         if (wr_ok && is_mask) begin
            irq_mask <= wb_dat_i[4:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus answer

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= `PFFB_RST_DAT;
      end else begin
         wb_ack_o <= req & hit;
         wb_err_o <= req & ~hit;
         wb_dat_o <= (req & ~wb_we_i) ? {24'h00_0000, rd_byte} : `PFFB_RST_DAT;
      end
   end

   assign irq_o = |(irq_stat & irq_mask);

endmodule

`default_nettype wire

//--- rtl/pffb_defines.svh
`ifndef PFFB_DEFINES_SVH
`define PFFB_DEFINES_SVH

// Register byte offsets
`define PFFB_OFF_THERM      8'h00
`define PFFB_OFF_LP_ALERT   8'h04
`define PFFB_OFF_LP_FAULT   8'h08
`define PFFB_OFF_PF_ALERT   8'h0C
`define PFFB_OFF_PF_STATUS  8'h10
`define PFFB_OFF_EN_BASE    8'h20
`define PFFB_OFF_EN_LAST    8'h30
`define PFFB_OFF_IRQ_STAT   8'h40
`define PFFB_OFF_IRQ_MASK   8'h44

// Bits that exist in each flag register
`define PFFB_MASK_THERM     8'hF7
`define PFFB_MASK_LP_ALERT  8'hF0
`define PFFB_MASK_LP_FAULT  8'hF6
`define PFFB_MASK_PF        8'hDF
`define PFFB_MASK_SUSPEND   8'h08

// Interrupt status bit positions
`define PFFB_IRQ_THERM      0
`define PFFB_IRQ_LP_ALERT   1
`define PFFB_IRQ_LP_FAULT   2
`define PFFB_IRQ_PF_ALERT   3
`define PFFB_IRQ_PF_STATUS  4

// Reset values
`define PFFB_RST_FLAG       8'h00
`define PFFB_RST_EN         8'hFF
`define PFFB_RST_IRQ        5'h00
`define PFFB_RST_DAT        32'h0000_0000

`endif

//--- rtl/pffb_pkg.sv
package pffb_pkg;

   typedef logic [7:0] pffb_byte_t;

   typedef struct packed {
      logic fet_overtemp_flag;
      logic internal_overtemp_flag;
      logic discharge_overtemp_flag;
      logic charge_overtemp_flag;
      logic reserved_zero_bit;
      logic internal_undertemp_flag;
      logic discharge_undertemp_flag;
      logic charge_undertemp_flag;
   } pffb_thermal_t;

   typedef struct packed {
      logic       tier3_discharge_overcurrent_flag;
      logic       short_circuit_latch_flag;
      logic       discharge_overcurrent_latch_flag;
      logic       cell_overvoltage_latch_flag;
      logic       precharge_timeout_suspended;
      logic [2:0] reserved_zero_bit;
   } pffb_lp_alert_t;

   typedef struct packed {
      logic tier3_discharge_overcurrent_flag;
      logic short_circuit_latch_flag;
      logic discharge_overcurrent_latch_flag;
      logic cell_overvoltage_latch_flag;
      logic reserved_zero_bit;
      logic precharge_timeout_flag;
      logic host_watchdog_flag;
      logic reserved_zero_bit_low;
   } pffb_lp_fault_t;

   typedef struct packed {
      logic copper_deposition_flag;
      logic safety_fet_overtemp_flag;
      logic reserved_zero_bit;
      logic safety_overtemp_flag;
      logic safety_discharge_overcurrent_flag;
      logic safety_charge_overcurrent_flag;
      logic safety_cell_overvoltage_flag;
      logic safety_cell_undervoltage_flag;
   } pffb_pf_t;

endpackage

//--- tb/pffb_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pffb_checker
   import pffb_pkg::*;
(
   input wire logic           clk_i,
   input wire logic           rst_i,
   input wire logic           wb_cyc_i,
   input wire logic           wb_stb_i,
   input wire logic           wb_we_i,
   input wire logic [7:0]     wb_adr_i,
   input wire logic [31:0]    wb_dat_o,
   input wire logic           wb_ack_o,
   input wire logic           wb_err_o,
   input wire pffb_lp_alert_t lp_alert_trig_i
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_rd(logic [7:0] a);
      wb_ack_o && !wb_we_i && wb_adr_i == a;
   endsequence
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_answer_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o)
      else $error("no single answer");
   a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("upper data set");
   a_therm_rsvd: assert property (s_rd(8'h00) |-> !wb_dat_o[3])
      else $error("thermal spare bit set");
   a_alert_rsvd: assert property (s_rd(8'h04) |-> wb_dat_o[2:0] == 3'h0)
      else $error("alert spare bits set");
   a_suspend_live: assert property (s_rd(8'h04) |-> wb_dat_o[3] == $past(lp_alert_trig_i[3], 2))
      else $error("suspend bit wrong");
   a_fault_rsvd: assert property (s_rd(8'h08) |-> wb_dat_o[3] == 1'b0 && wb_dat_o[0] == 1'b0)
      else $error("fault spare bits set");
   a_pf_rsvd: assert property (s_rd(8'h0C) |-> !wb_dat_o[5])
      else $error("pf spare bit set");
endmodule
bind pffb_flag_bank pffb_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .wb_err_o, .lp_alert_trig_i);
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import pffb_pkg::*;
;
   logic           clk_i = 1'b0;
   logic           rst_i = 1'b1;
   logic           wb_cyc_i = 1'b0;
   logic           wb_stb_i = 1'b0;
   logic           wb_we_i = 1'b0;
   logic [7:0]     wb_adr_i = 8'h00;
   logic [3:0]     wb_sel_i = 4'hF;
   logic [31:0]    wb_dat_i = 32'h0;
   logic [31:0]    wb_dat_o;
   logic           wb_ack_o;
   logic           wb_err_o;
   logic           irq_o;
   pffb_thermal_t  therm_trig_i = '0;
   pffb_lp_alert_t lp_alert_trig_i = '0;
   pffb_lp_fault_t lp_fault_trig_i = '0;
   pffb_pf_t       pf_alert_trig_i = '0;
   pffb_pf_t       pf_status_trig_i = '0;
   logic [7:0]     en [5];
   logic [7:0]     tr [5];
   logic [31:0]    q;
   logic           e;
   logic [31:0]    seed = 32'hD786567C;
   int             error_cnt = 0;
   int             samples_checked = 0;
   int             cycles = 0;
   localparam logic [7:0] VM [5] = '{8'hF7, 8'hF0, 8'hF6, 8'hDF, 8'hDF};

   pffb_flag_bank DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .wb_err_o, .therm_trig_i, .lp_alert_trig_i, .lp_fault_trig_i,
      .pf_alert_trig_i, .pf_status_trig_i, .irq_o);

   always #12.5 clk_i = ~clk_i;
////////////////////////////////////////
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Suspend bit passes ungated
   function automatic logic [31:0] expf(input int k);
      return {24'h0, (tr[k] & en[k] & VM[k]) | (k == 1 ? tr[1] & 8'h08 : 8'h00)};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (!(wb_ack_o || wb_err_o));
      q = wb_dat_o;
      e = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic results;
      if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         results();
      end
   end
////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int k = 0; k < 5; k++) begin
         bus(1'b0, 8'(4 * k), 32'h0);
         chk(q, 32'h0);
         bus(1'b0, 8'(32 + 4 * k), 32'h0);
         chk(q, 32'hFF);
      end
      for (int n = 0; n < 30; n++) begin
         for (int k = 0; k < 5; k++) begin
            seed = lfsr(seed);
            en[k] = seed[7:0];
            tr[k] = seed[15:8];
            bus(1'b1, 8'(32 + 4 * k), seed);
            bus(1'b1, 8'(4 * k), ~seed);
         end
         therm_trig_i <= tr[0];
         lp_alert_trig_i <= tr[1];
         lp_fault_trig_i <= tr[2];
         pf_alert_trig_i <= tr[3];
         pf_status_trig_i <= tr[4];
         for (int k = 0; k < 5; k++) begin
            bus(1'b0, 8'(4 * k), 32'h0);
            chk(q, expf(k));
         end
      end
      // Quiet thermal and LP fault flags, then clear pending events
      therm_trig_i <= '0;
      lp_fault_trig_i <= '0;
      bus(1'b1, 8'h20, 32'hFF);
      bus(1'b1, 8'h28, 32'hFF);
      bus(1'b0, 8'h40, 32'h0);
      therm_trig_i <= 8'h80;
      lp_fault_trig_i <= 8'h80;
      bus(1'b0, 8'h00, 32'h0);
      chk(q, 32'h80);
      chk({31'h0, irq_o}, 32'h0);
      bus(1'b1, 8'h44, 32'h1);
      chk({31'h0, irq_o}, 32'h1);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h5);
      bus(1'b0, 8'h44, 32'h0);
      chk(q, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      // Status ignores writes; sel[0] low blocks a write
      bus(1'b1, 8'h40, 32'h1F);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      wb_sel_i <= 4'hE;
      bus(1'b1, 8'h24, 32'h0);
      wb_sel_i <= 4'hF;
      bus(1'b0, 8'h24, 32'h0);
      chk(q, {24'h0, en[1]});
      chk({31'h0, e}, 32'h0);
      // New event on the clearing edge survives
      fork
         bus(1'b0, 8'h40, 32'h0);
         begin
            @(posedge clk_i);
            therm_trig_i <= 8'hC0;
         end
      join
      chk(q, 32'h0);
      chk({31'h0, irq_o}, 32'h1);
      bus(1'b0, 8'h40, 32'h0);
      chk(q, 32'h1);
      chk({31'h0, irq_o}, 32'h0);
      bus(1'b0, 8'h50, 32'h0);
      chk({31'h0, e}, 32'h1);
      bus(1'b1, 8'h02, 32'hFF);
      chk({31'h0, e}, 32'h1);
      results();
   end
endmodule
`default_nettype wire
